// ===== common/i2cm_pkg.sv
// types of the i2c master
package i2cm_pkg;
  typedef enum logic [4:0] {
    st_idle = 5'h01,
    st_start = 5'h02,
    st_bit = 5'h04,
    st_wait = 5'h08,
    st_stop = 5'h10
  } i2cm_state_t;
endpackage

// ===== common/i2cm_regs.svh
// register indices, field positions, reset values and timing for the i2c master
`ifndef I2CM_REGS_SVH
`define I2CM_REGS_SVH
// register indices; byte address is four times the index
`define I2CM_IDX_RX 16'hf2a0
`define I2CM_IDX_SA 16'hf2a1
`define I2CM_IDX_TD 16'hf2a2
`define I2CM_IDX_CTL 16'hf2a3
`define I2CM_IDX_MODE 16'hf2a4
`define I2CM_IDX_STAT 16'hf2a5
`define I2CM_RST_BYTE 8'h00
// transfer_control bits
`define I2CM_CTL_START 0
`define I2CM_CTL_STOP 1
`define I2CM_CTL_RS 2
`define I2CM_CTL_ACK 7
// bus_mode bits
`define I2CM_MODE_EN 0
`define I2CM_MODE_FAST 1
`define I2CM_MODE_DW 2
`define I2CM_MODE_SYN 4
// bit periods and quarter-bit counts, rounded up
`define I2CM_CLK_MHZ 100
`define I2CM_STD_BIT_NS 10000
`define I2CM_FAST_BIT_NS 2500
`define I2CM_STD_QTR ((`I2CM_STD_BIT_NS * `I2CM_CLK_MHZ + 3999) / 4000)
`define I2CM_FAST_QTR ((`I2CM_FAST_BIT_NS * `I2CM_CLK_MHZ + 3999) / 4000)
`define I2CM_ACK_BIT 4'd8
`endif

// ===== design/i2cm_top.sv
// single-channel i2c bus master with a wishbone register file
//
// The Wishbone slave port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
`include "i2cm_regs.svh"

// Operation
// - master only, 7-bit addressing, one channel
// - 100 kbps standard, 400 kbps fast mode
// - wait on scl held low by others
// - rx_byte read-only, updated per byte
// - sample sda each scl rise, own bits too
// - address bits 7-1, direction bit 0
// - tx_byte read-write, next byte shifted out
// - start bit from idle issues start condition
// - wait after ack, start bit resumes
// - writing start and stop bits both 0 aborts immediately
// - start bit settable only when enabled
// - stop bit issues stop, clears start
// - restart bit only while started, reads zero
// - ack level after receive from bit 7
// - disable returns interface registers to reset
// - busy set on any start, cleared on stop
// - received ack kept in status bit 1
// - address byte msb first, ack, wait
module i2cm_top (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // i2c pins, open drain
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_n_o
);

  // ****************************************
  // bus slave
  // ****************************************
  logic ack_r;
  logic [7:0] rdat_r;
  wire req = wb_cyc_i & wb_stb_i;
  wire wr_fire = req & ack_r & wb_we_i & wb_sel_i[0];
  wire a_rx = (wb_adr_i == {14'h0000, `I2CM_IDX_RX, 2'b00});
  wire a_sa = (wb_adr_i == {14'h0000, `I2CM_IDX_SA, 2'b00});
  wire a_td = (wb_adr_i == {14'h0000, `I2CM_IDX_TD, 2'b00});
  wire a_ctl = (wb_adr_i == {14'h0000, `I2CM_IDX_CTL, 2'b00});
  wire a_mode = (wb_adr_i == {14'h0000, `I2CM_IDX_MODE, 2'b00});
  wire a_stat = (wb_adr_i == {14'h0000, `I2CM_IDX_STAT, 2'b00});
  wire [7:0] wd = wb_dat_i[7:0];

  logic [7:0] rx_r, sa_r, td_r, mode_r;
  logic start_r, ackout_r, busy_r, ackin_r, er_r, kill_r;
  logic [3:0] ctl_spare_r;
  wire en = mode_r[`I2CM_MODE_EN];
  wire syn = mode_r[`I2CM_MODE_SYN];
  wire wr_ctl = wr_fire & a_ctl & en;
  wire [7:0] ctl_rd = {ackout_r, ctl_spare_r, 2'b00, start_r};
  wire [7:0] stat_rd = {5'h00, er_r, ackin_r, busy_r};
  wire [7:0] rd_mux = a_rx ? rx_r : a_sa ? sa_r : a_td ? td_r : a_ctl ? ctl_rd :
                      a_mode ? mode_r : a_stat ? stat_rd : 8'h00;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_r <= 1'b0;
      rdat_r <= 8'h00;
    end else begin
      ack_r <= req & ~ack_r;
      if (req & ~ack_r) begin
        rdat_r <= rd_mux;
      end
    end
  end
  assign wb_ack_o = ack_r;
  assign wb_dat_o = {24'h000000, rdat_r};

  // ****************************************
  // pin synchronisers and line events
  // ****************************************
  logic [1:0] sda_sy, scl_sy;
  logic sda_d, scl_d;
  wire sda_s = sda_sy[1];
  wire scl_s = scl_sy[1];
  wire scl_rise = scl_s & ~scl_d;
  wire line_start = scl_s & scl_d & sda_d & ~sda_s;
  wire line_stop = scl_s & scl_d & ~sda_d & sda_s;
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sda_sy <= 2'b11;
      scl_sy <= 2'b11;
      sda_d <= 1'b1;
      scl_d <= 1'b1;
    end else begin
      sda_sy <= {sda_sy[0], sda_i};
      scl_sy <= {scl_sy[0], scl_i};
      sda_d <= sda_s;
      scl_d <= scl_s;
    end
  end

  // ****************************************
  // bit timing
  // ****************************************
  i2cm_pkg::i2cm_state_t state_r, state_nxt;
  logic [1:0] ph_r, ph_nxt;
  logic [3:0] bit_r, bit_nxt;
  logic [7:0] shf_r, shf_nxt, rsh_r;
  logic [9:0] cnt_r, cnt_nxt;
  logic sdal_r, sdal_nxt, scll_r, scll_nxt, addr_r, addr_nxt;
  wire [9:0] q_base = mode_r[`I2CM_MODE_FAST] ? 10'(`I2CM_FAST_QTR) : 10'(`I2CM_STD_QTR);
  wire [9:0] q_ext = q_base * {8'h00, mode_r[`I2CM_MODE_DW +: 2]} / 10'd10;
  wire [9:0] reload = q_base + q_ext - 10'd1;
  wire tick = (cnt_r == 10'd0);
  wire on_bus = (state_r == i2cm_pkg::st_bit) | (state_r == i2cm_pkg::st_start) |
                (state_r == i2cm_pkg::st_stop);
  wire stretch = syn & on_bus & ~scll_r & ~scl_s;
  assign cnt_nxt = stretch ? cnt_r : (tick | (state_nxt != state_r)) ? reload : cnt_r - 10'd1;

  // ****************************************
  // control decode
  // ****************************************
  wire is_idle = (state_r == i2cm_pkg::st_idle);
  wire stop_go = wr_ctl & wd[`I2CM_CTL_STOP] & ~is_idle;
  wire abort = wr_ctl & ~wd[`I2CM_CTL_START] & ~wd[`I2CM_CTL_STOP] & ~is_idle;
  wire start_go = wr_ctl & wd[`I2CM_CTL_START] & ~wd[`I2CM_CTL_STOP] & is_idle & ~start_r;
  wire resume = wr_ctl & wd[`I2CM_CTL_START] & ~wd[`I2CM_CTL_STOP] & (state_r == i2cm_pkg::st_wait);
  wire rs_go = wd[`I2CM_CTL_RS] & start_r;
  wire txm = addr_r | ~sa_r[0];
  wire bit_low = kill_r ? 1'b0 : (bit_r == `I2CM_ACK_BIT) ? (~txm & ~ackout_r) : (txm & ~shf_r[7]);
  wire tx_err = scl_rise & (state_r == i2cm_pkg::st_bit) & (bit_r != `I2CM_ACK_BIT) & txm & shf_r[7] & ~sda_s;

  // ****************************************
  // transfer sequencer
  // ****************************************
  always_comb begin
    state_nxt = state_r;
    ph_nxt = ph_r;
    bit_nxt = bit_r;
    sdal_nxt = sdal_r;
    scll_nxt = scll_r;
    shf_nxt = shf_r;
    addr_nxt = addr_r;
    if (!en | abort) begin
      state_nxt = i2cm_pkg::st_idle;
      sdal_nxt = 1'b0;
      scll_nxt = 1'b0;
    end else if (stop_go) begin
      state_nxt = i2cm_pkg::st_stop;
      ph_nxt = 2'd0;
    end else begin
      case (state_r)
        i2cm_pkg::st_idle: begin
          if (start_go) begin
            state_nxt = i2cm_pkg::st_start;
            ph_nxt = 2'd0;
          end
        end
        i2cm_pkg::st_start: begin
          if (tick) begin
            ph_nxt = ph_r + 2'd1;
            case (ph_r)
              2'd0: sdal_nxt = 1'b0;
              2'd1: scll_nxt = 1'b0;
              2'd2: sdal_nxt = 1'b1;
              default: begin
                scll_nxt = 1'b1;
                state_nxt = i2cm_pkg::st_bit;
                bit_nxt = 4'd0;
                addr_nxt = 1'b1;
                shf_nxt = sa_r;
              end
            endcase
          end
        end
        i2cm_pkg::st_bit: begin
          if (tick) begin
            ph_nxt = ph_r + 2'd1;
            case (ph_r)
              2'd0: sdal_nxt = bit_low;
              2'd1: scll_nxt = 1'b0;
              2'd2: scll_nxt = 1'b0;
              default: begin
                scll_nxt = 1'b1;
                shf_nxt = {shf_r[6:0], 1'b0};
                if (bit_r == `I2CM_ACK_BIT) begin
                  state_nxt = i2cm_pkg::st_wait;
                end else begin
                  bit_nxt = bit_r + 4'd1;
                end
              end
            endcase
          end
        end
        i2cm_pkg::st_wait: begin
          sdal_nxt = 1'b0;
          if (resume & rs_go) begin
            state_nxt = i2cm_pkg::st_start;
            ph_nxt = 2'd0;
          end else if (resume) begin
            state_nxt = i2cm_pkg::st_bit;
            ph_nxt = 2'd0;
            bit_nxt = 4'd0;
            addr_nxt = 1'b0;
            shf_nxt = td_r;
          end
        end
        i2cm_pkg::st_stop: begin
          if (tick) begin
            ph_nxt = ph_r + 2'd1;
            case (ph_r)
              2'd0: begin
                scll_nxt = 1'b1;
                sdal_nxt = 1'b1;
              end
              2'd1: scll_nxt = 1'b0;
              default: begin
                sdal_nxt = 1'b0;
                state_nxt = i2cm_pkg::st_idle;
              end
            endcase
          end
        end
        default: state_nxt = i2cm_pkg::st_idle;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= i2cm_pkg::st_idle;
      ph_r <= 2'd0;
      bit_r <= 4'd0;
      shf_r <= 8'h00;
      cnt_r <= 10'd0;
      sdal_r <= 1'b0;
      scll_r <= 1'b0;
      addr_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      ph_r <= ph_nxt;
      bit_r <= bit_nxt;
      shf_r <= shf_nxt;
      cnt_r <= cnt_nxt;
      sdal_r <= sdal_nxt;
      scll_r <= scll_nxt;
      addr_r <= addr_nxt;
    end
  end
  assign sda_o = 1'b0;
  assign scl_o = 1'b0;
  assign sda_oe_n_o = ~sdal_r;
  assign scl_oe_n_o = ~scll_r;

  // ****************************************
  // registers, sampling and status
  // ****************************************
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_r <= `I2CM_RST_BYTE;
      rx_r <= `I2CM_RST_BYTE;
      sa_r <= `I2CM_RST_BYTE;
      td_r <= `I2CM_RST_BYTE;
      rsh_r <= 8'h00;
      ctl_spare_r <= 4'h0;
      {start_r, ackout_r, busy_r, ackin_r, er_r, kill_r} <= 6'h00;
    end else begin
      if (wr_fire & a_mode) begin
        mode_r <= wd;
      end
      if (!en) begin
        rx_r <= `I2CM_RST_BYTE;
        sa_r <= `I2CM_RST_BYTE;
        td_r <= `I2CM_RST_BYTE;
        rsh_r <= 8'h00;
        ctl_spare_r <= 4'h0;
        {start_r, ackout_r, busy_r, ackin_r, er_r, kill_r} <= 6'h00;
      end else begin
        if (wr_fire & a_sa) begin
          sa_r <= wd;
        end
        if (wr_fire & a_td) begin
          td_r <= wd;
        end
        if (wr_ctl) begin
          ackout_r <= wd[`I2CM_CTL_ACK];
          ctl_spare_r <= wd[6:3];
          start_r <= wd[`I2CM_CTL_START] & ~wd[`I2CM_CTL_STOP];
        end else if (state_r == i2cm_pkg::st_stop) begin
          start_r <= 1'b0;
        end
        if (scl_rise & (state_r == i2cm_pkg::st_bit)) begin
          rsh_r <= {rsh_r[6:0], sda_s};
          if (bit_r == 4'd7) begin
            rx_r <= {rsh_r[6:0], sda_s};
          end
          if (bit_r == `I2CM_ACK_BIT) begin
            ackin_r <= sda_s;
          end
        end
        if (line_start) begin
          busy_r <= 1'b1;
        end else if (line_stop) begin
          busy_r <= 1'b0;
        end
        if (tx_err) begin
          er_r <= 1'b1;
        end else if (wr_ctl) begin
          er_r <= 1'b0;
        end
        if (tx_err & syn) begin
          kill_r <= 1'b1;
        end else if (state_r != i2cm_pkg::st_bit) begin
          kill_r <= 1'b0;
        end
      end
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  a_start_gate: assert property (!en |-> !start_r) else $error("start bit set while disabled");
  a_stop_clear: assert property (stop_go |=> !start_r && state_r == i2cm_pkg::st_stop)
    else $error("stop did not clear start");
  a_start_cond: assert property (start_go |=> state_r == i2cm_pkg::st_start)
    else $error("start not issued");
  a_abort_idle: assert property (abort && en |=> state_r == i2cm_pkg::st_idle && sda_oe_n_o && scl_oe_n_o)
    else $error("abort did not release bus");
  a_wait_hold: assert property (state_r == i2cm_pkg::st_wait && !wr_ctl && en |=> state_r == i2cm_pkg::st_wait)
    else $error("left wait without software");
  a_busy_off: assert property (!en |=> !busy_r) else $error("busy while disabled");
  a_ack_store: assert property (scl_rise && en && state_r == i2cm_pkg::st_bit && bit_r == `I2CM_ACK_BIT
    |=> ackin_r == $past(sda_s)) else $error("ack level not stored");
  a_disable_clr: assert property (!en |=> rx_r == 8'h00 && sa_r == 8'h00 && td_r == 8'h00 && !er_r)
    else $error("registers not cleared on disable");
  a_rs_gate: assert property (wr_ctl && wd[`I2CM_CTL_RS] && !wd[`I2CM_CTL_START] && !start_r
    |=> state_r != i2cm_pkg::st_start) else $error("restart accepted while stopped");
  a_addr_load: assert property (state_r == i2cm_pkg::st_start && state_nxt == i2cm_pkg::st_bit
    |=> shf_r == sa_r && addr_r && bit_r == 4'd0) else $error("address byte not loaded");
  a_rx_ro: assert property (wr_fire && a_rx && !scl_rise |=> $stable(rx_r))
    else $error("rx_byte changed by write");

  c_start: cover property (state_r == i2cm_pkg::st_start ##1 state_r == i2cm_pkg::st_bit);
  c_wait: cover property (state_r == i2cm_pkg::st_bit ##1 state_r == i2cm_pkg::st_wait);
  c_stop: cover property (state_r == i2cm_pkg::st_stop ##1 state_r == i2cm_pkg::st_idle);
  c_err: cover property (tx_err);

endmodule
`default_nettype wire

// ===== verif/i2cm_slave_model.sv
// behavioural i2c target that answers the master under test
`timescale 1ns/10ps
`default_nettype none
module i2cm_slave_model #(
  parameter logic [6:0] ADDR = 7'h5a,
  parameter logic [7:0] RDATA = 8'hc3,
  parameter int STRETCH_NS = 6000
) (
  // resolved bus lines, pulled up
  input wire logic scl_i,
  input wire logic sda_i,
  // hold scl low once in the address byte
  input wire logic stretch_i,
  // pulls, high holds the line low
  output logic sda_pull_o,
  output logic scl_pull_o,
  // last byte and ack level seen on the bus
  output logic [7:0] byte_o,
  output logic ack_o
);
  logic act = 1'b0;
  logic addr_ph = 1'b0;
  logic match = 1'b0;
  logic rd = 1'b0;
  logic [3:0] cnt = 4'h0;
  logic [7:0] sh = 8'h00;
  initial begin
    {sda_pull_o, scl_pull_o, ack_o, byte_o} = 11'h000;
  end
  // ****************************************
  // start, stop and bit tracking
  // ****************************************
  always @(negedge sda_i) begin
    if (scl_i === 1'b1) begin
      {act, addr_ph, cnt} = {2'b11, 4'h0};
    end
  end
  always @(posedge sda_i) begin
    if (scl_i === 1'b1) begin
      act = 1'b0;
    end
  end
  always @(posedge scl_i) begin
    if (act) begin
      if (cnt == 4'h8) {byte_o, ack_o} = {sh, sda_i};
      else sh = {sh[6:0], sda_i};
      cnt = cnt + 4'h1;
    end
  end
  // data changes only while scl is low; lines are only pulled or released
  always @(negedge scl_i) begin
    if (act) begin
      if (cnt == 4'h8 && addr_ph) {match, rd} = {sh[7:1] == ADDR, sh[0]};
      if (cnt == 4'h9) {cnt, addr_ph} = 5'h00;
      // ack address and written bytes; send read bytes until the master declines
      sda_pull_o = (cnt == 4'h8) ? (match && (addr_ph || !rd)) :
        (match && rd && !addr_ph && !ack_o && !RDATA[3'h7 - cnt[2:0]]);
      if (stretch_i && addr_ph && cnt == 4'h4) begin
        scl_pull_o = 1'b1;
        #(STRETCH_NS);
        scl_pull_o = 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ===== verif/test_i2cm_top.sv
// self-checking bench for the i2c master: register access and bus transfers
`timescale 1ns/10ps
`default_nettype none
`include "i2cm_regs.svh"
module test_i2cm_top;
  localparam int T_ST = 4 * `I2CM_FAST_QTR;
  localparam int T_BY = 36 * `I2CM_FAST_QTR + 40;
  logic core_clk_i, rst_n_i, cyc, stb, we, ack, sda_oe_n, scl_oe_n, pull_sda, pull_scl, stretch, slv_ack;
  logic [31:0] adr, dat_w, dat_r;
  logic [7:0] slv_byte;
  int num_errors = 0, compares = 0, cycles = 0, rises = 0, r0;
  wire logic sda_w = sda_oe_n & ~pull_sda;
  wire logic scl_w = scl_oe_n & ~pull_scl;
  i2cm_top dut_u (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack), .sda_i(sda_w),
    .sda_o(), .sda_oe_n_o(sda_oe_n), .scl_i(scl_w), .scl_o(), .scl_oe_n_o(scl_oe_n));
  i2cm_slave_model #(.ADDR(7'h5a), .RDATA(8'hc3)) slv_u (.scl_i(scl_w), .sda_i(sda_w), .stretch_i(stretch),
    .sda_pull_o(pull_sda), .scl_pull_o(pull_scl), .byte_o(slv_byte), .ack_o(slv_ack));
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  always @(posedge scl_w) rises++;
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [15:0] idx, input logic [7:0] d, output logic [7:0] q);
    int t;
    t = 0;
    @(posedge core_clk_i);
    {cyc, stb, we} <= {2'b11, w};
    adr <= {14'h0000, idx, 2'b00};
    dat_w <= {24'h000000, d};
    do begin
      @(posedge core_clk_i);
      t++;
    end while (ack !== 1'b1 && t < 50);
    if (t >= 50) num_errors++;
    q = dat_r[7:0];
    {cyc, stb} <= 2'b00;
  endtask
  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    logic [7:0] q;
    xfer(1'b1, idx, d, q);
  endtask
  task automatic rc(input logic [15:0] idx, input logic [7:0] e);
    logic [7:0] q;
    xfer(1'b0, idx, 8'h00, q);
    check(q, e);
  endtask
  task automatic wait_cy(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask
  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    {rst_n_i, cyc, stb, we, stretch} = 5'h00;
    adr = 32'h00000000;
    dat_w = 32'h00000000;
    wait_cy(20);
    rst_n_i <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      rc(`I2CM_IDX_RX + 16'(i), 8'h00);
    end
    wr(`I2CM_IDX_SA, 8'ha5);
    rc(`I2CM_IDX_SA, 8'h00);
    wr(`I2CM_IDX_CTL, 8'h01);
    rc(`I2CM_IDX_CTL, 8'h00);
    wr(`I2CM_IDX_MODE, 8'h03);
    rc(`I2CM_IDX_MODE, 8'h03);
    wr(`I2CM_IDX_SA, 8'ha5);
    rc(`I2CM_IDX_SA, 8'ha5);
    wr(`I2CM_IDX_TD, 8'h3c);
    rc(`I2CM_IDX_TD, 8'h3c);
    wr(`I2CM_IDX_RX, 8'hff);
    rc(`I2CM_IDX_RX, 8'h00);
    wr(`I2CM_IDX_CTL, 8'h06);
    rc(`I2CM_IDX_CTL, 8'h00);
    $display("register test done");
    rc(`I2CM_IDX_STAT, 8'h00);
    wr(`I2CM_IDX_SA, 8'hb4);
    wr(`I2CM_IDX_CTL, 8'h01);
    wait_cy(T_ST + T_BY);
    rc(`I2CM_IDX_RX, 8'hb4);
    rc(`I2CM_IDX_STAT, 8'h01);
    rc(`I2CM_IDX_CTL, 8'h01);
    check({6'h00, scl_oe_n, sda_oe_n}, 8'h01);
    wr(`I2CM_IDX_CTL, 8'h01);
    wait_cy(T_BY);
    rc(`I2CM_IDX_RX, 8'h3c);
    check(slv_byte, 8'h3c);
    wr(`I2CM_IDX_CTL, 8'h02);
    wait_cy(T_ST);
    rc(`I2CM_IDX_STAT, 8'h00);
    rc(`I2CM_IDX_CTL, 8'h00);
    check({6'h00, scl_oe_n, sda_oe_n}, 8'h03);
    $display("write test done");
    wr(`I2CM_IDX_SA, 8'hb5);
    wr(`I2CM_IDX_CTL, 8'h01);
    wait_cy(T_ST + T_BY);
    rc(`I2CM_IDX_STAT, 8'h01);
    wr(`I2CM_IDX_CTL, 8'h01);
    wait_cy(T_BY);
    check({7'h00, slv_ack}, 8'h00);
    wr(`I2CM_IDX_CTL, 8'h81);
    wait_cy(T_BY);
    rc(`I2CM_IDX_RX, 8'hc3);
    check({7'h00, slv_ack}, 8'h01);
    wr(`I2CM_IDX_CTL, 8'h85);
    wait_cy(T_ST + T_BY);
    rc(`I2CM_IDX_RX, 8'hb5);
    wr(`I2CM_IDX_CTL, 8'h00);
    wait_cy(3);
    check({6'h00, scl_oe_n, sda_oe_n}, 8'h03);
    rc(`I2CM_IDX_STAT, 8'h01);
    wr(`I2CM_IDX_MODE, 8'h00);
    rc(`I2CM_IDX_STAT, 8'h00);
    $display("read test done");
    stretch <= 1'b1;
    wr(`I2CM_IDX_MODE, 8'h13);
    wr(`I2CM_IDX_SA, 8'h22);
    r0 = rises;
    wr(`I2CM_IDX_CTL, 8'h01);
    wait_cy(T_ST + T_BY - 40);
    // the held low phase delays bits 4 on, so only bits 0 to 6 have risen yet
    check(8'(rises - r0), 8'h07);
    wait_cy(700);
    check(8'(rises - r0), 8'h09);
    rc(`I2CM_IDX_STAT, 8'h03);
    wr(`I2CM_IDX_CTL, 8'h02);
    wait_cy(T_ST);
    // the address was refused, so the stored ack level stays high after the stop
    rc(`I2CM_IDX_STAT, 8'h02);
    $display("stretch test done");
    // 30% slow-down: quarter of 81 cycles, so 7 rises where full speed gives 9
    stretch <= 1'b0;
    wr(`I2CM_IDX_MODE, 8'h0f);
    wr(`I2CM_IDX_SA, 8'hb4);
    r0 = rises;
    wr(`I2CM_IDX_CTL, 8'h01);
    wait_cy(T_ST + T_BY);
    check(8'(rises - r0), 8'h07);
    wait_cy(800);
    check(8'(rises - r0), 8'h09);
    rc(`I2CM_IDX_RX, 8'hb4);
    wr(`I2CM_IDX_CTL, 8'h02);
    wait_cy(2 * T_ST);
    rc(`I2CM_IDX_STAT, 8'h00);
    $display("slow-down test done");
    give_verdict();
  end
endmodule
`default_nettype wire
